// [verilog/tmr_slice.sv]
// timer slice: channel mode, forced compare, channel-7 override, main count
// assumes an apb master, an external prescaler tick and compare match strobes
//
// What this block does
// RULE_01: mode bit clear means input capture, set means output compare.
// RULE_02: bits of absent channels ignore writes and read zero.
// RULE_03: force register always reads zero.
// RULE_04: writing a force one performs the channel's compare pin action now.
// RULE_05: forced actions never set the channel flag.
// RULE_06: force coinciding with real match wins; flag not set.
// RULE_07: channel-7 event overrides compare actions on channels 6 to 0.
// RULE_08: on channel-7 event masked pins take channel-7 data bits.
// RULE_09: data reaches pin only if output compare and pin connected.
// RULE_10: absent channel 7 makes mask and data registers reserved zero.
// RULE_11: mask and data reset to zero, access any time.
// RULE_12: count is a 16-bit up counter readable any time.
// RULE_13: software reads the count as one word to stay consistent.
// RULE_14: count writes ignored unless test mode is asserted.
// RULE_15: first period after a count write may differ in length.
// RULE_16: counter runs unless the run enable bit is clear.
// RULE_17: registers at indices 0 to 5 in documented order.
// RULE_18: counter wraps all-ones to zero on tick; wrap is overflow.
// RULE_19: all pin updates resolve in one cycle with set precedence.
`timescale 1ns/1ps
module tmr_slice
(
   // clock and reset
   input  wire logic        pclk,
   input  wire logic        presetn,
   // apb slave
   input  wire logic        psel,
   input  wire logic        penable,
   input  wire logic        pwrite,
   input  wire logic [11:0] paddr,
   input  wire logic [31:0] pwdata,
   input  wire logic [3:0]  pstrb,
   output logic      [31:0] prdata,
   output logic             pready,
   output logic             pslverr,
   // timer context
   input  wire logic        test_mode,
   input  wire logic        prescale_tick,
   input  wire logic [7:0]  compare_match,
   input  wire logic [7:0]  compare_action_level,
   // channel pins and status
   output logic      [7:0]  chan_pin_out,
   output logic      [7:0]  chan_pin_oe,
   output logic      [7:0]  chan_flag_set,
   output logic             count_wrap,
   output logic             irq
);
   // ==========================================================
   // registers
   logic [7:0]  func_sel_r;
   logic [7:0]  c7_mask_r;
   logic [7:0]  c7_data_r;
   logic [7:0]  wrap_tgl_r;
   logic [7:0]  pin_disc_r;
   logic        run_en_r;
   logic [15:0] count_r;
   logic [15:0] count_nxt;
   logic [7:0]  pin_r;
   logic [7:0]  pin_nxt;
   logic [2:0]  irq_stat_r;
   logic [2:0]  irq_mask_r;
   logic [2:0]  irq_stat_nxt;

   // masks a byte to implemented channels
   function automatic logic [7:0] chan_only(input logic [7:0] v);
      chan_only = v & tmr_slice_pkg::CHAN_PRESENT;
   endfunction

   // ==========================================================
   // apb decode: zero wait states, unmapped address gives pslverr
   wire [9:0] word_idx = paddr[11:tmr_slice_pkg::ADDR_SHIFT];
   wire       acc      = psel & penable;
   wire       wr       = acc & pwrite & pstrb[0];
   wire       hit_fs   = word_idx == {2'h0, tmr_slice_pkg::IDX_FUNC_SEL};
   wire       hit_fc   = word_idx == {2'h0, tmr_slice_pkg::IDX_FORCE};
   wire       hit_mk   = word_idx == {2'h0, tmr_slice_pkg::IDX_C7_MASK};
   wire       hit_dt   = word_idx == {2'h0, tmr_slice_pkg::IDX_C7_DATA};
   wire       hit_ch   = word_idx == {2'h0, tmr_slice_pkg::IDX_COUNT_HI};
   wire       hit_cl   = word_idx == {2'h0, tmr_slice_pkg::IDX_COUNT_LO};
   wire       hit_ct   = word_idx == {2'h0, tmr_slice_pkg::IDX_CTRL};
   wire       hit_tg   = word_idx == {2'h0, tmr_slice_pkg::IDX_WRAP_TGL};
   wire       hit_pd   = word_idx == {2'h0, tmr_slice_pkg::IDX_PIN_DISC};
   wire       hit_is   = word_idx == {2'h0, tmr_slice_pkg::IDX_IRQ_STAT};
   wire       hit_im   = word_idx == {2'h0, tmr_slice_pkg::IDX_IRQ_MASK};
   wire       hit_cw   = word_idx == {2'h0, tmr_slice_pkg::IDX_COUNT_WORD};
   wire       mapped   = hit_fs | hit_fc | hit_mk | hit_dt | hit_ch | hit_cl
                         | hit_ct | hit_tg | hit_pd | hit_is | hit_im | hit_cw; // RULE_17
   wire       c7_here  = tmr_slice_pkg::CHAN_PRESENT[tmr_slice_pkg::CHAN7];

   // ==========================================================
   // forced compare strobe lasts only the write cycle
   wire [7:0] force_hit = (wr & hit_fc) ? chan_only(pwdata[7:0]) : 8'h00; // RULE_04
   wire [7:0] oc_chan   = chan_only(func_sel_r);                          // RULE_01
   wire [7:0] drive_ok  = oc_chan & ~pin_disc_r;                          // RULE_09

   // ==========================================================
   // counter: wrap forms overflow; test-mode writes bypass prescaler
   wire       count_step = run_en_r & prescale_tick;                      // RULE_16
   wire       wrap_now   = count_step & (count_r == 16'hffff);            // RULE_18
   wire       cnt_wr_hi  = wr & test_mode & (hit_ch | hit_cw);            // RULE_14
   wire       cnt_wr_lo  = wr & test_mode & (hit_cl | hit_cw);            // RULE_14

   // next count value; a write preempts the tick without resync
   always_comb
   begin
      count_nxt = count_r;
      if (count_step)
      begin
         count_nxt = count_r + 16'h0001;                                  // RULE_12
      end
      if (hit_cw && cnt_wr_hi)
      begin
         count_nxt = pwdata[15:0];                                        // RULE_15
      end
      else if (cnt_wr_hi)
      begin
         count_nxt = {pwdata[7:0], count_r[7:0]};
      end
      else if (cnt_wr_lo)
      begin
         count_nxt = {count_r[15:8], pwdata[7:0]};
      end
   end

   // ==========================================================
   // pin resolver: channel-7 event > force or real match > wrap toggle
   tmr_slice_pkg::cmp_events_t ev;
   assign ev.match     = compare_match & oc_chan;
   assign ev.force_hit = force_hit;
   assign ev.c7_event  = c7_here & (ev.match[tmr_slice_pkg::CHAN7]
                         | ev.force_hit[tmr_slice_pkg::CHAN7]
                         | (wrap_now & wrap_tgl_r[tmr_slice_pkg::CHAN7]));  // RULE_07

   wire [7:0] act      = (ev.match | ev.force_hit) & drive_ok;
   wire [7:0] c7_take  = ev.c7_event ? (c7_mask_r & drive_ok) : 8'h00;    // RULE_08
   wire [7:0] wrap_act = wrap_now ? (wrap_tgl_r & drive_ok) : 8'h00;
   wire [7:0] flag_nxt = ev.match & ~ev.force_hit;                        // RULE_05 RULE_06

   // resolve all pin sources in a single cycle
   always_comb
   begin
      pin_nxt = pin_r;
      pin_nxt = pin_nxt ^ wrap_act;
      pin_nxt = (pin_nxt & ~act) | (compare_action_level & act);          // RULE_04
      pin_nxt = (pin_nxt & ~c7_take) | (c7_data_r & c7_take);             // RULE_07 RULE_19
   end

   // sticky status: set wins over write-one clear
   wire [2:0] irq_ev = {|force_hit, ev.c7_event, wrap_now};
   always_comb
   begin
      irq_stat_nxt = irq_stat_r;
      if (wr && hit_is)
      begin
         irq_stat_nxt = irq_stat_r & ~pwdata[2:0];
      end
      irq_stat_nxt = irq_stat_nxt | irq_ev;
   end

   // ==========================================================
   // read mux
   logic [31:0] rd_val;
   always_comb
   begin
      rd_val = 32'h0000_0000;
      case (1'b1)
         hit_fs: rd_val[7:0]  = chan_only(func_sel_r);                    // RULE_02
         hit_fc: rd_val[7:0]  = 8'h00;                                    // RULE_03
         hit_mk: rd_val[7:0]  = c7_here ? c7_mask_r : 8'h00;              // RULE_10
         hit_dt: rd_val[7:0]  = c7_here ? c7_data_r : 8'h00;              // RULE_10
         hit_ch: rd_val[7:0]  = count_r[15:8];
         hit_cl: rd_val[7:0]  = count_r[7:0];
         hit_cw: rd_val[15:0] = count_r;                                  // RULE_13
         hit_ct: rd_val[0]    = run_en_r;
         hit_tg: rd_val[7:0]  = wrap_tgl_r;
         hit_pd: rd_val[7:0]  = pin_disc_r;
         hit_is: rd_val[2:0]  = irq_stat_r;
         hit_im: rd_val[2:0]  = irq_mask_r;
         default: rd_val      = 32'h0000_0000;
      endcase
   end

   // ==========================================================
   // configuration registers: named write strobes, one short process each
   wire       we_fs    = wr & hit_fs;
   wire       we_mk    = wr & hit_mk & c7_here;                           // RULE_10
   wire       we_dt    = wr & hit_dt & c7_here;                           // RULE_10
   wire       we_tg    = wr & hit_tg;
   wire       we_pd    = wr & hit_pd;
   wire       we_ct    = wr & hit_ct;
   wire       we_im    = wr & hit_im;

   // channel mode: bits of absent channels stay zero
   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         func_sel_r <= tmr_slice_pkg::BYTE_RST;
      end
      else if (we_fs)
      begin
         func_sel_r <= chan_only(pwdata[7:0]);                            // RULE_02
      end
   end

   // channel-7 event pin mask
   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         c7_mask_r <= tmr_slice_pkg::BYTE_RST;                            // RULE_11
      end
      else if (we_mk)
      begin
         c7_mask_r <= pwdata[7:0];                                        // RULE_10
      end
   end

   // channel-7 event pin data
   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         c7_data_r <= tmr_slice_pkg::BYTE_RST;                            // RULE_11
      end
      else if (we_dt)
      begin
         c7_data_r <= pwdata[7:0];                                        // RULE_10
      end
   end

   // toggle-on-wrap bits
   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         wrap_tgl_r <= tmr_slice_pkg::BYTE_RST;
      end
      else if (we_tg)
      begin
         wrap_tgl_r <= chan_only(pwdata[7:0]);
      end
   end

   // compare pin disconnect bits
   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         pin_disc_r <= tmr_slice_pkg::BYTE_RST;
      end
      else if (we_pd)
      begin
         pin_disc_r <= chan_only(pwdata[7:0]);
      end
   end

   // counter run enable
   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         run_en_r <= 1'b0;
      end
      else if (we_ct)
      begin
         run_en_r <= pwdata[tmr_slice_pkg::CTRL_RUN_BIT];                 // RULE_16
      end
   end

   // interrupt mask
   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         irq_mask_r <= 3'h0;
      end
      else if (we_im)
      begin
         irq_mask_r <= pwdata[2:0];
      end
   end

   // ==========================================================
   // timer state: count, pins and sticky status
   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         count_r    <= tmr_slice_pkg::COUNT_RST;
         pin_r      <= tmr_slice_pkg::BYTE_RST;
         irq_stat_r <= 3'h0;
      end
      else
      begin
         count_r    <= count_nxt;
         pin_r      <= pin_nxt;                                           // RULE_19
         irq_stat_r <= irq_stat_nxt;
      end
   end

   // one-cycle pulses: flag setter and counter wrap
   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         chan_flag_set <= 8'h00;
         count_wrap    <= 1'b0;
      end
      else
      begin
         chan_flag_set <= flag_nxt;                                       // RULE_05
         count_wrap    <= wrap_now;                                       // RULE_18
      end
   end

   // level interrupt, high while an unmasked status bit is set
   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         irq <= 1'b0;
      end
      else
      begin
         irq <= |(irq_stat_nxt & irq_mask_r);
      end
   end

   // pin drivers follow mode and disconnect bits
   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         chan_pin_oe <= 8'h00;
      end
      else
      begin
         chan_pin_oe <= drive_ok;                                         // RULE_09
      end
   end

   assign chan_pin_out = pin_r;

   // apb answer registers
   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         prdata  <= 32'h0000_0000;
         pready  <= 1'b0;
         pslverr <= 1'b0;
      end
      else
      begin
         pready  <= psel & ~penable;
         pslverr <= psel & ~penable & ~mapped;
         prdata  <= rd_val;
      end
   end
endmodule

// [verilog/tmr_slice_pkg.sv]
// package for the timer channel mode, force and counter slice
// assumes an apb slave with 32-bit data, one register per aligned word
package tmr_slice_pkg;
   // ==========================================================
   // register word indices (printed offsets are indices)
   localparam logic [7:0] IDX_FUNC_SEL   = 8'h00;
   localparam logic [7:0] IDX_FORCE      = 8'h01;
   localparam logic [7:0] IDX_C7_MASK    = 8'h02;
   localparam logic [7:0] IDX_C7_DATA    = 8'h03;
   localparam logic [7:0] IDX_COUNT_HI   = 8'h04;
   localparam logic [7:0] IDX_COUNT_LO   = 8'h05;
   localparam logic [7:0] IDX_CTRL       = 8'h10;
   localparam logic [7:0] IDX_WRAP_TGL   = 8'h11;
   localparam logic [7:0] IDX_PIN_DISC   = 8'h12;
   localparam logic [7:0] IDX_IRQ_STAT   = 8'h13;
   localparam logic [7:0] IDX_IRQ_MASK   = 8'h14;
   localparam logic [7:0] IDX_COUNT_WORD = 8'h15;
   localparam int         ADDR_SHIFT     = 2;
   // ==========================================================
   // field positions and reset values
   localparam int         CTRL_RUN_BIT   = 0;
   localparam int         IRQ_WRAP_BIT   = 0;
   localparam int         IRQ_C7EV_BIT   = 1;
   localparam int         IRQ_FORCE_BIT  = 2;
   localparam logic [7:0] BYTE_RST       = 8'h00;
   localparam logic [15:0] COUNT_RST     = 16'h0000;
   localparam logic [7:0] CHAN_PRESENT   = 8'hff;
   localparam int         CHAN7          = 7;

   // compare-side event bundle seen by the pin resolver
   typedef struct packed {
      logic [7:0] match;
      logic [7:0] force_hit;
      logic       c7_event;
   } cmp_events_t;
endpackage

// [test/tmr_slice_checker.sv]
// checker of the timer slice, bound to the ports of its top module
// assumes one clock domain with an active-low asynchronous reset
`timescale 1ns/1ps
module tmr_slice_checker
(
   // clock, reset and bus
   input wire logic        pclk,
   input wire logic        presetn,
   input wire logic        psel,
   input wire logic        penable,
   input wire logic        pwrite,
   input wire logic [11:0] paddr,
   input wire logic [31:0] pwdata,
   input wire logic [3:0]  pstrb,
   input wire logic [31:0] prdata,
   input wire logic        pready,
   input wire logic        pslverr,
   // timer side
   input wire logic        prescale_tick,
   input wire logic [7:0]  compare_match,
   input wire logic [7:0]  chan_pin_out,
   input wire logic [7:0]  chan_pin_oe,
   input wire logic [7:0]  chan_flag_set,
   input wire logic        count_wrap
);
   default clocking cb @(posedge pclk); endclocking
   default disable iff (!presetn);
   // write landing at the access edge
   wire wr_acc = psel & penable & pwrite & pstrb[0];
   rdy_access_a: assert property (psel && !penable |=> pready) else $error("no ready");
   unmapped_err_a: assert property (psel && penable && paddr == 12'h018 |-> pslverr)
      else $error("no slave error");
   force_zero_a: assert property (psel && penable && !pwrite && paddr == 12'h004
      |-> prdata == 32'h0) else $error("force reads nonzero");
   flag_cause_a: assert property ((chan_flag_set & ~$past(compare_match)) == 8'h00)
      else $error("flag without match");
   force_flag_a: assert property (wr_acc && paddr == 12'h004
      |=> (chan_flag_set & $past(pwdata[7:0])) == 8'h00) else $error("flag on forced channel");
   wrap_tick_a: assert property (count_wrap |-> $past(prescale_tick) || $past(prescale_tick, 2))
      else $error("wrap without tick");
   pin_cause_a: assert property ($changed(chan_pin_out) |-> $past(prescale_tick)
      || $past(compare_match) != 8'h00 || $past(wr_acc)) else $error("pin moved with no cause");
   oe_write_a: assert property ($changed(chan_pin_oe) |-> $past(wr_acc) || $past(wr_acc, 2))
      else $error("enable moved with no write");
endmodule
bind tmr_slice tmr_slice_checker u_tmr_slice_checker (.pclk, .presetn, .psel, .penable,
   .pwrite, .paddr, .pwdata, .pstrb, .prdata, .pready, .pslverr, .prescale_tick,
   .compare_match, .chan_pin_out, .chan_pin_oe, .chan_flag_set, .count_wrap);

// [test/tmr_far_model.sv]
// far-side model: prescaler tick source and compare match strobes
// assumes the bench asks for one match strobe by toggling match_go
`timescale 1ns/1ps
module tmr_far_model
(
   // clock, reset and bench requests
   input  wire logic       pclk,
   input  wire logic       presetn,
   input  wire logic       tick_en,
   input  wire logic       match_go,
   input  wire logic [7:0] match_req,
   // strobes into the timer
   output logic            prescale_tick,
   output logic      [7:0] compare_match
);
   logic [1:0] div_r;
   logic       go_r;
   // a tick every fourth cycle; a match strobe lasts one cycle
   always_ff @(posedge pclk or negedge presetn)
      if (!presetn)
         {div_r, go_r, prescale_tick, compare_match} <= '0;
      else
      begin
         div_r <= div_r + 2'h1;
         go_r <= match_go;
         prescale_tick <= tick_en && div_r == 2'h3;
         compare_match <= (match_go != go_r) ? match_req : 8'h00;
      end
endmodule

// [test/test_tmr_slice.sv]
// bench of the timer slice: apb tasks, far-side model, random stimulus
// assumes package, design, checker and model are compiled first
`timescale 1ns/1ps
module test_tmr_slice;
   logic        pclk = '0, presetn = '0, psel = '0, penable = '0, pwrite = '0, err;
   logic        test_mode = '0, tick_en = '0, match_go = '0, pready, pslverr, prescale_tick;
   logic        count_wrap, irq, wrap_seen = '0;
   logic [11:0] paddr = '0;
   logic [31:0] pwdata = '0, prdata, d, c0, sd = 32'hd9be;
   logic [7:0]  lvl = '0, match_req = '0, compare_match, flag_acc = '0, m, p;
   logic [7:0]  chan_pin_out, chan_pin_oe, chan_flag_set;
   int          failures = 0, n_tests = 0, ticks = 0, i;
   tmr_slice u_tmr_slice (.pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata,
      .pstrb(4'hf), .prdata, .pready, .pslverr, .test_mode, .prescale_tick, .compare_match,
      .compare_action_level(lvl), .chan_pin_out, .chan_pin_oe, .chan_flag_set, .count_wrap, .irq);
   tmr_far_model u_tmr_far_model (.pclk, .presetn, .tick_en, .match_go, .match_req,
      .prescale_tick, .compare_match);
   // clock, and a monitor of ticks, wraps and flag pulses
   always #5 pclk = ~pclk;
   always @(posedge pclk)
   begin
      ticks += (prescale_tick === 1'b1);
      wrap_seen |= (count_wrap === 1'b1);
      flag_acc |= chan_flag_set;
   end
   // xorshift source and expected pins after a channel-7 force
   function automatic logic [31:0] nxt(input logic [31:0] x);
      x ^= x << 13;
      x ^= x >> 17;
      return x ^ (x << 5);
   endfunction
   function automatic logic [7:0] c7_pins(input logic [7:0] pv, lv, mk, dt);
      return (pv & ~(mk | 8'h80)) | (lv & 8'h80 & ~mk) | (dt & mk);
   endfunction
   task automatic chk(input string nm, input logic [31:0] got, exp);
      n_tests++;
      if (got !== exp)
      begin
         failures++;
         $display("[ERR] %s exp %h got %h", nm, exp, got);
      end
   endtask
   task automatic cyc(input int k);
      repeat (k) @(posedge pclk);
   endtask
   // one apb transfer; read data and error land in d and err
   task automatic apb(input logic w, input logic [7:0] idx, input logic [31:0] wd);
      int n = 0;
      @(posedge pclk);
      psel <= 1'b1;
      pwrite <= w;
      paddr <= {2'h0, idx, 2'h0};
      pwdata <= wd;
      @(posedge pclk);
      penable <= 1'b1;
      do
         @(posedge pclk);
      while (pready !== 1'b1 && ++n < 50);
      d = prdata;
      err = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
      failures += (n >= 50);
   endtask
   task automatic stop_test;
      $display("checks %0d failures %0d", n_tests, failures);
      if (failures == 0 && n_tests > 0)
         $display("TB: PASS");
      else
         $display("TB: FAIL");
      $finish;
   endtask
   initial
   begin
      cyc(5);
      presetn <= 1'b1;
      apb(0, 8'h03, 0);
      chk("data rst", d, 0);
      apb(0, 8'h06, 0);
      chk("unmapped", err, 1);
      // random mode, one pin disconnected
      sd = nxt(sd);
      apb(1, 8'h00, sd);
      apb(1, 8'h12, 1);
      apb(0, 8'h00, 0);
      chk("mode", d, sd[7:0]);
      apb(0, 8'h01, 0);
      chk("force rd", d, 0);
      chk("pin oe", chan_pin_oe, sd[7:0] & 8'hfe);
      // force all channels, then channel 7 with channels 3..0
      apb(1, 8'h00, 8'hff);
      apb(1, 8'h12, 0);
      lvl <= sd[15:8];
      apb(1, 8'h01, 8'hff);
      cyc(3);
      chk("forced", chan_pin_out, sd[15:8]);
      m = sd[23:16];
      apb(1, 8'h02, 8'h0f);
      apb(1, 8'h03, m);
      apb(0, 8'h03, 0);
      chk("data rw", d, m);
      p = chan_pin_out;
      sd = nxt(sd);
      lvl <= sd[7:0];
      apb(1, 8'h01, 8'h8f);
      cyc(3);
      chk("c7 pins", chan_pin_out, c7_pins(p, lvl, 8'h0f, m));
      chk("no flags", flag_acc, 0);
      // real match on channels 6..0
      m = sd[15:8] & 8'h7f;
      p = chan_pin_out;
      match_req <= m;
      match_go <= ~match_go;
      cyc(4);
      chk("flags", flag_acc, m);
      chk("match pins", chan_pin_out, (p & ~m) | (lvl & m));
      // force on channel 0 lands on the same edge as a match on channels 1..0
      flag_acc = '0;
      match_req <= 8'h03;
      fork
         apb(1, 8'h01, 8'h01);
         begin
            cyc(1);
            match_go <= ~match_go;
         end
      join
      cyc(3);
      chk("force wins", flag_acc, 8'h02);
      // count held, then running, then written
      tick_en <= 1'b1;
      apb(0, 8'h15, 0);
      c0 = d;
      cyc(20);
      apb(0, 8'h15, 0);
      chk("held", d, c0);
      apb(1, 8'h10, 1);
      tick_en <= 1'b0;
      cyc(4);
      apb(0, 8'h15, 0);
      c0 = d;
      ticks = 0;
      tick_en <= 1'b1;
      cyc(40);
      tick_en <= 1'b0;
      cyc(4);
      apb(1, 8'h15, 32'h1234);
      apb(0, 8'h15, 0);
      chk("count", d, c0 + ticks);
      test_mode <= 1'b1;
      apb(1, 8'h15, 32'hfffd);
      test_mode <= 1'b0;
      apb(0, 8'h15, 0);
      chk("test wr", d, 32'hfffd);
      // wrap raises the unmasked interrupt; writing one clears it
      chk("irq masked", irq, 0);
      apb(1, 8'h14, 1);
      ticks = 0;
      tick_en <= 1'b1;
      for (i = 0; i < 100 && !wrap_seen; i++)
         cyc(1);
      tick_en <= 1'b0;
      cyc(4);
      chk("wrap irq", {wrap_seen, irq}, 2'h3);
      apb(0, 8'h15, 0);
      chk("wrapped", d, (32'hfffd + ticks) & 32'hffff);
      apb(1, 8'h13, 1);
      cyc(3);
      chk("irq clr", irq, 0);
      stop_test();
   end
   initial
   begin
      #100000;
      failures++;
      stop_test();
   end
endmodule
